// file: bench/adcx_i2c_ctrl.sv
// controller model for the serial bus side of the auxiliary config bank
// assumes sda_i is the resolved wire level with the off-chip pull-up applied
`timescale 1ns/1ps
module adcx_i2c_ctrl #(
  parameter int QTR = 10                    // clocks per quarter bit period
) (
  input  wire logic core_clk_i,             // system clock
  input  wire logic sda_i,                  // resolved data wire level
  output logic      scl_o,                  // serial clock, only this model moves it
  output logic      sda_pull_o              // high while pulling sda low
);
  // ==========================================================================
  // idle bus: both lines released to the pull-ups
  initial begin
    scl_o      = 1'b1;
    sda_pull_o = 1'b0;
  end

  // ==========================================================================
  // bit level helpers; every change lands just after a clock edge
  task automatic qwait();
    repeat (QTR) @(posedge core_clk_i);
  endtask

  // one clock pulse; no wait for a held-low clock, the target never stretches
  task automatic pulse(output logic bit_o);
    scl_o <= 1'b1;
    qwait();
    bit_o = sda_i;                          // mid-high sample, clear of both edges
    qwait();
    scl_o <= 1'b0;
    qwait();
  endtask

  // start or repeated start: sda falls while scl is high
  task automatic bus_start();
    sda_pull_o <= 1'b0;
    qwait();
    scl_o <= 1'b1;
    qwait();
    sda_pull_o <= 1'b1;
    qwait();
    scl_o <= 1'b0;
    qwait();
  endtask

  // stop: sda rises while scl is high
  task automatic bus_stop();
    sda_pull_o <= 1'b1;
    qwait();
    scl_o <= 1'b1;
    qwait();
    sda_pull_o <= 1'b0;
    qwait();
  endtask

  // ==========================================================================
  // byte level; callers zero reserved bits but also hand the unlisted route codes 2 to 4
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_pull_o <= ~b[i];                  // msb first
      qwait();
      pulse(s);
    end
    sda_pull_o <= 1'b0;                     // release so the target can answer
    qwait();
    pulse(s);
    ack = ~s;
  endtask

  task automatic get_byte(input logic nack, output logic [7:0] b);
    logic s;
    sda_pull_o <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      qwait();
      pulse(s);
      b[i] = s;
    end
    sda_pull_o <= ~nack;                    // nack ends the read burst
    qwait();
    pulse(s);
  endtask
endmodule

// file: bench/adcx_tb.sv
// self-checking bench for the auxiliary config bank over its serial target port
// assumes the default strap base of the address decoder and pull-ups on sda
`timescale 1ns/1ps
module testbench
  import adcx_pkg::*;
;
  localparam logic [2:0] BASE_HI = 3'h4;   // upper address bits of the default base

  logic       core_clk = 1'b0;
  logic       rst;
  logic [1:0] strap_low, strap_high;
  logic       conv_done, conv_read;
  logic       scl, sda_pull, sda_o, sda_oe, sda_line;
  logic       rdy_o, rdy_oe, flag, data_counter_enable, burnout_source_enable;
  logic [1:0] integ;
  logic [2:0] curr, route1, route2;
  logic [6:0] dev_addr;
  logic [7:0] rd, route_val;
  logic       ack;
  int         failures = 0;
  int         check_count = 0;
  logic [7:0] cfg_tab [6] = '{8'hC1, 8'h1A, 8'h24, 8'h4D, 8'h2F, 8'h08};

  // ==========================================================================
  // clock, wire resolution and instances
  always #5 core_clk = ~core_clk;

  // open-drain wire: low if anyone pulls, else the pull-up wins
  assign sda_line = (sda_oe ? sda_o : 1'b1) & ~sda_pull;
  assign dev_addr = {BASE_HI, strap_high, strap_low};

  adcx_cfg_bank adcx_cfg_bank_inst (
    .core_clk_i                   (core_clk),
    .rst_i                        (rst),
    .scl_i                        (scl),
    .sda_i                        (sda_line),
    .sda_o                        (sda_o),
    .sda_oe_o                     (sda_oe),
    .address_select_pin_low_i     (strap_low),
    .address_select_pin_high_i    (strap_high),
    .conv_done_i                  (conv_done),
    .conv_data_read_i             (conv_read),
    .ready_pin_o                  (rdy_o),
    .ready_pin_oe_o               (rdy_oe),
    .conversion_ready_flag_o      (flag),
    .data_counter_enable_o        (data_counter_enable),
    .integrity_mode_o             (integ),
    .burnout_source_enable_o      (burnout_source_enable),
    .excitation_current_setting_o (curr),
    .first_source_route_o         (route1),
    .second_source_route_o        (route2)
  );

  adcx_i2c_ctrl adcx_i2c_ctrl_inst (
    .core_clk_i (core_clk),
    .sda_i      (sda_line),
    .scl_o      (scl),
    .sda_pull_o (sda_pull)
  );

  // ==========================================================================
  // compare and bus access helpers
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected value at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic check_outputs(input logic [7:0] cfg, input logic [7:0] route);
    check({flag, data_counter_enable, integ, burnout_source_enable, curr}, cfg);
    check({route1, route2, 2'b00}, route);
  endtask

  task automatic send(input logic [7:0] b);
    adcx_i2c_ctrl_inst.put_byte(b, ack);
    check({7'h00, ack}, 8'h01);
  endtask

  task automatic reg_write(input logic [7:0] ptr, input logic [7:0] data);
    adcx_i2c_ctrl_inst.bus_start();
    send({dev_addr, 1'b0});
    send(ptr);
    send(data);
    adcx_i2c_ctrl_inst.bus_stop();
  endtask

  task automatic reg_read(input logic [7:0] ptr, output logic [7:0] data);
    adcx_i2c_ctrl_inst.bus_start();
    send({dev_addr, 1'b0});
    send(ptr);
    adcx_i2c_ctrl_inst.bus_start();
    send({dev_addr, 1'b1});
    adcx_i2c_ctrl_inst.get_byte(1'b1, data);
    adcx_i2c_ctrl_inst.bus_stop();
  endtask

  // address byte alone, then stop; a stranger address must stay unanswered
  task automatic addr_probe(input logic [6:0] addr, input logic exp_ack);
    adcx_i2c_ctrl_inst.bus_start();
    adcx_i2c_ctrl_inst.put_byte({addr, 1'b0}, ack);
    adcx_i2c_ctrl_inst.bus_stop();
    check({7'h00, ack}, {7'h00, exp_ack});
  endtask

  // one-cycle pulses on the converter event inputs
  task automatic pulse_conv(input logic done, input logic rd_done);
    @(posedge core_clk);
    conv_done <= done;
    conv_read <= rd_done;
    @(posedge core_clk);
    conv_done <= 1'b0;
    conv_read <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic print_verdict();
    $display("checks %0d, failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    rst        = 1'b1;
    strap_low  = 2'h1;
    strap_high = 2'h2;
    conv_done  = 1'b0;
    conv_read  = 1'b0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    check_outputs(8'h00, 8'h00);
    reg_read(ADCX_OFS_STATUS_CFG, rd);
    check(rd, ADCX_RST_STATUS_CFG);
    reg_read(ADCX_OFS_ROUTING, rd);
    check(rd, ADCX_RST_ROUTING);
    // every listed integrity and current code, bit 7 written high once
    foreach (cfg_tab[i]) begin
      reg_write(ADCX_OFS_STATUS_CFG, cfg_tab[i]);
      check_outputs(cfg_tab[i] & 8'h7F, 8'h00);
      reg_read(ADCX_OFS_STATUS_CFG, rd);
      check(rd, cfg_tab[i] & 8'h7F);
    end
    // every listed route code on both sources, reserved bits written zero
    for (int r = 0; r < 7; r++) begin
      route_val = {r[2:0], 3'(6 - r), 2'b00};
      reg_write(ADCX_OFS_ROUTING, route_val);
      check_outputs(8'h08, route_val);
      reg_read(ADCX_OFS_ROUTING, rd);
      check(rd, route_val);
    end
    // unmapped pointer: write dropped, read gives zero
    reg_write(8'h05, 8'hFF);
    reg_read(8'h05, rd);
    check(rd, ADCX_RD_UNMAPPED);
    check_outputs(8'h08, 8'hC0);
    // ready flag: set, clear, and set winning over a same-cycle clear
    pulse_conv(1'b1, 1'b0);
    check({5'h00, rdy_o, rdy_oe, flag}, 8'h03);
    reg_read(ADCX_OFS_STATUS_CFG, rd);
    check(rd, 8'h88);
    pulse_conv(1'b0, 1'b1);
    check({5'h00, rdy_o, rdy_oe, flag}, 8'h00);
    pulse_conv(1'b1, 1'b1);
    check({5'h00, rdy_o, rdy_oe, flag}, 8'h03);
    // all sixteen strap codes, each behind a mid-run reset
    for (int s = 0; s < 16; s++) begin
      @(posedge core_clk);
      rst <= 1'b1;
      {strap_high, strap_low} <= s[3:0];
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      addr_probe({BASE_HI, s[3:0] ^ 4'h1}, 1'b0);
      addr_probe({BASE_HI, s[3:0]}, 1'b1);
    end
    check_outputs(8'h00, 8'h00);
    check({7'h00, rdy_oe}, 8'h00);
    reg_read(ADCX_OFS_STATUS_CFG, rd);
    check(rd, ADCX_RST_STATUS_CFG);
    print_verdict();
  end

  // run takes near 60k clocks; far beyond that means a hung transfer
  initial begin
    repeat (90000) @(posedge core_clk);
    failures++;
    print_verdict();
  end
endmodule

// file: design/adcx_addr_sel.sv
// bus address decoder from the two four-level address strap pins
// assumes strap codes are stable around reset release and synchronous to clk
`timescale 1ns/1ps
module adcx_addr_sel
  import adcx_pkg::*;
#(
  parameter logic [6:0] ADDR_BASE = 7'h48        // arbitrary value, board picks real one
) (
  input  wire logic       core_clk_i,               // system clock
  input  wire logic       rst_i,                    // async reset, active high
  input  wire logic [1:0] address_select_pin_low_i, // strap level code of low pin
  input  wire logic [1:0] address_select_pin_high_i,// strap level code of high pin
  output logic      [6:0] dev_addr_o                // latched target address
);

  logic strap_taken;

  // ==========================================================================
  // strap capture: taken once after reset release, never from the port at reset
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_taken <= 1'b0;
      dev_addr_o  <= ADCX_ADDR_BASE_RST;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      // two pins of four levels each give sixteen distinct addresses, see R12
      dev_addr_o  <= {ADDR_BASE[6:4], address_select_pin_high_i, address_select_pin_low_i};
    end
  end

endmodule

// file: design/adcx_cfg_bank.sv
// auxiliary configuration bank of the converter with its serial target port
// assumes scl/sda inputs already synchronous to core_clk_i, pull-ups off chip
//
// Notes on behaviour
// [R1] ready flag sets on result, clears on read
// [R2] bit 6 enables the data counter
// [R3] bits 5:4 pick integrity check mode
// [R4] bit 3 switches burn-out current sources
// [R5] bits 2:0 set shared excitation current
// [R6] routing bits 7:5 steer first source
// [R7] routing bits 4:2 steer second source
// [R8] routing bits 1:0 read zero, write zero
// [R9] routing register sits at 03h, resets 00h
// [R10] never holds the serial clock low
// [R11] plain target for all three speeds
// [R12] two strap pins select sixteen addresses
// [R13] ready pin is open drain, low only
// [R14] status/config register at 02h, resets 00h
// [R15] controller avoids reserved or unlisted encodings; the bench writes unlisted route codes 2 to 4
`timescale 1ns/1ps
module adcx_cfg_bank
  import adcx_pkg::*;
(
  input  wire logic       core_clk_i,                   // 100 MHz system clock
  input  wire logic       rst_i,                        // async reset, active high
  input  wire logic       scl_i,                        // serial clock level
  input  wire logic       sda_i,                        // serial data level
  output logic            sda_o,                        // serial data drive value
  output logic            sda_oe_o,                     // high while pulling sda low
  input  wire logic [1:0] address_select_pin_low_i,     // low strap pin level code
  input  wire logic [1:0] address_select_pin_high_i,    // high strap pin level code
  input  wire logic       conv_done_i,                  // pulse: new result ready
  input  wire logic       conv_data_read_i,             // pulse: result has been read
  output logic            ready_pin_o,                  // open-drain ready value
  output logic            ready_pin_oe_o,               // high while pulling ready low
  output logic            conversion_ready_flag_o,      // ready flag level
  output logic            data_counter_enable_o,        // counter enable
  output logic      [1:0] integrity_mode_o,             // integrity check mode
  output logic            burnout_source_enable_o,      // burn-out sources on
  output logic      [2:0] excitation_current_setting_o, // shared source current
  output logic      [2:0] first_source_route_o,         // first source routing
  output logic      [2:0] second_source_route_o         // second source routing
);

  adcx_state_t state;
  logic [6:0]  dev_addr;
  logic [7:0]  shreg;
  logic [7:0]  ptr;
  logic [3:0]  bit_cnt;
  logic        rw_read;
  logic        host_ack;
  logic        sda_drive;
  logic        scl_q;
  logic        sda_q;
  logic        start_det;
  logic        stop_det;
  logic        scl_rise;
  logic        scl_fall;
  logic        wr_fire;
  logic [6:0]  cfg;
  logic [5:0]  route;
  logic [7:0]  rd_view;

  // ==========================================================================
  // register read view, used only by the read shifter
  function automatic logic [7:0] reg_view(input logic [7:0] ofs, input logic rdy,
                                          input logic [6:0] c, input logic [5:0] r);
    if (ofs == ADCX_OFS_STATUS_CFG) begin
      return {rdy, c};
    end else if (ofs == ADCX_OFS_ROUTING) begin
      return {r, ADCX_ROUTE_RSVD_VAL}; // reserved pair reads zero, see R8
    end else begin
      return ADCX_RD_UNMAPPED;
    end
  endfunction

  // byte the read shifter loads; a select on a call result is not legal, so it is named
  assign rd_view = reg_view(ptr, conversion_ready_flag_o, cfg, route);

  adcx_addr_sel u_addr_sel (
    .core_clk_i                (core_clk_i),
    .rst_i                     (rst_i),
    .address_select_pin_low_i  (address_select_pin_low_i),
    .address_select_pin_high_i (address_select_pin_high_i),
    .dev_addr_o                (dev_addr)
  );

  // ==========================================================================
  // line history for edge and start/stop detection
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  assign start_det = scl_i && scl_q && sda_q && !sda_i;
  assign stop_det  = scl_i && scl_q && !sda_q && sda_i;
  assign scl_rise  = scl_i && !scl_q;
  assign scl_fall  = !scl_i && scl_q;
  assign wr_fire   = (state == ADCX_ST_WDATA) && scl_fall && (bit_cnt == ADCX_BYTE_BITS);

  // ==========================================================================
  // serial target; no speed-dependent timing, oversampled at 100 MHz, see R11
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state     <= ADCX_ST_IDLE;
      shreg     <= 8'h00;
      ptr       <= 8'h00;
      bit_cnt   <= 4'h0;
      rw_read   <= 1'b0;
      host_ack  <= 1'b0;
      sda_drive <= 1'b0;
    end else if (start_det) begin
      // repeated start keeps the pointer so a read follows a pointer write
      state     <= ADCX_ST_ADDR;
      bit_cnt   <= 4'h0;
      sda_drive <= 1'b0;
    end else if (stop_det) begin
      state     <= ADCX_ST_IDLE;
      sda_drive <= 1'b0;
    end else begin
      case (state)
        ADCX_ST_ADDR, ADCX_ST_PTR, ADCX_ST_WDATA: begin
          if (scl_rise && bit_cnt != ADCX_BYTE_BITS) begin
            shreg   <= {shreg[6:0], sda_i};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == ADCX_BYTE_BITS) begin
            bit_cnt <= 4'h0;
            if (state == ADCX_ST_ADDR) begin
              // answer only our strapped address, see R12
              if (shreg[7:1] == dev_addr) begin
                rw_read   <= shreg[0];
                sda_drive <= 1'b1;
                state     <= ADCX_ST_ADDR_ACK;
              end else begin
                state <= ADCX_ST_IDLE;
              end
            end else if (state == ADCX_ST_PTR) begin
              ptr       <= shreg;
              sda_drive <= 1'b1;
              state     <= ADCX_ST_PTR_ACK;
            end else begin
              sda_drive <= 1'b1;
              state     <= ADCX_ST_WDATA_ACK;
            end
          end
        end
        ADCX_ST_ADDR_ACK, ADCX_ST_PTR_ACK, ADCX_ST_WDATA_ACK: begin
          // sda only moves while scl is low; scl itself is never driven, see R10
          if (scl_fall) begin
            if (state == ADCX_ST_ADDR_ACK && rw_read) begin
              shreg     <= rd_view;
              sda_drive <= !rd_view[7];
              state     <= ADCX_ST_RDATA;
            end else begin
              sda_drive <= 1'b0;
              state     <= (state == ADCX_ST_ADDR_ACK) ? ADCX_ST_PTR : ADCX_ST_WDATA;
            end
            if (state == ADCX_ST_WDATA_ACK) begin
              ptr <= ptr + 8'h01;
            end
          end
        end
        ADCX_ST_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt[2:0] == ADCX_LAST_OUT_BIT) begin
              bit_cnt   <= 4'h0;
              sda_drive <= 1'b0;
              state     <= ADCX_ST_RDATA_ACK;
            end else begin
              bit_cnt   <= bit_cnt + 4'h1;
              shreg     <= {shreg[6:0], 1'b0};
              sda_drive <= !shreg[6];
            end
          end
        end
        ADCX_ST_RDATA_ACK: begin
          if (scl_rise) begin
            host_ack <= !sda_i;
          end else if (scl_fall) begin
            // a nack ends the read; an ack repeats the same register
            if (host_ack) begin
              shreg     <= rd_view;
              sda_drive <= !rd_view[7];
              state     <= ADCX_ST_RDATA;
            end else begin
              state <= ADCX_ST_IDLE;
            end
          end
        end
        default: begin
          state     <= ADCX_ST_IDLE;
          sda_drive <= 1'b0;
        end
      endcase
    end
  end

  // open-drain data line: value is always low, enable carries the bit
  assign sda_o    = 1'b0;
  assign sda_oe_o = sda_drive;

  // ==========================================================================
  // ready flag; a result in the clearing cycle wins so it is never lost
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      conversion_ready_flag_o <= 1'b0;
    end else if (conv_done_i) begin
      conversion_ready_flag_o <= 1'b1; // see R1
    end else if (conv_data_read_i) begin
      conversion_ready_flag_o <= 1'b0; // see R1
    end
  end

  // ready pin pulls low while a result waits, pull-up gives the high, see R13
  assign ready_pin_o    = 1'b0;
  assign ready_pin_oe_o = conversion_ready_flag_o;

  // ==========================================================================
  // status_and_excitation_config writable part at 02h
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg <= ADCX_RST_STATUS_CFG[6:0];
    end else if (wr_fire && ptr == ADCX_OFS_STATUS_CFG) begin
      cfg <= shreg[6:0]; // see R14; bit 7 is read-only and not stored, see R1
    end
  end

  // ==========================================================================
  // excitation_routing at 03h; reserved bits never stored, see R8
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      route <= ADCX_RST_ROUTING[7:2];
    end else if (wr_fire && ptr == ADCX_OFS_ROUTING) begin
      route <= shreg[7:2]; // see R9
    end
  end

  // ==========================================================================
  // field fan-out; reserved codes pass through as written, see R15
  assign data_counter_enable_o        = cfg[ADCX_POS_DATA_COUNTER_ENABLE];                      // see R2
  assign integrity_mode_o             = cfg[ADCX_POS_INTEG_H:ADCX_POS_INTEG_L];  // see R3
  assign burnout_source_enable_o      = cfg[ADCX_POS_BURNOUT];                   // see R4
  assign excitation_current_setting_o = cfg[ADCX_POS_CURR_H:ADCX_POS_CURR_L];    // see R5
  assign first_source_route_o  = route[ADCX_POS_ROUTE1_H-2:ADCX_POS_ROUTE1_L-2]; // see R6
  assign second_source_route_o = route[ADCX_POS_ROUTE2_H-2:ADCX_POS_ROUTE2_L-2]; // see R7

  // ==========================================================================
  // checks
  sequence s_addr_match;
    state == ADCX_ST_ADDR && scl_fall && bit_cnt == ADCX_BYTE_BITS && shreg[7:1] == dev_addr;
  endsequence

  sequence s_acked;
    sda_oe_o && state == ADCX_ST_ADDR_ACK;
  endsequence

  chk_ready_set: assert property (@(posedge core_clk_i) disable iff (rst_i) // see R1
    conv_done_i |=> conversion_ready_flag_o ##1 (conversion_ready_flag_o || $past(conv_data_read_i)))
    else $error("ready flag not set by new result");
  chk_ready_clear: assert property (@(posedge core_clk_i) disable iff (rst_i) // see R1
    conv_data_read_i && !conv_done_i |=> !conversion_ready_flag_o)
    else $error("ready flag not cleared by data read");
  chk_data_counter_enable_write: assert property (@(posedge core_clk_i) disable iff (rst_i) // see R2
    wr_fire && ptr == ADCX_OFS_STATUS_CFG |=> data_counter_enable_o == $past(shreg[6]))
    else $error("counter enable not written");
  chk_integ_write: assert property (@(posedge core_clk_i) disable iff (rst_i) // see R3
    wr_fire && ptr == ADCX_OFS_STATUS_CFG |=> integrity_mode_o == $past(shreg[5:4]))
    else $error("integrity mode not written");
  chk_burnout_write: assert property (@(posedge core_clk_i) disable iff (rst_i) // see R4
    wr_fire && ptr == ADCX_OFS_STATUS_CFG |=> burnout_source_enable_o == $past(shreg[3]))
    else $error("burn-out enable not written");
  chk_current_write: assert property (@(posedge core_clk_i) disable iff (rst_i) // see R5
    wr_fire && ptr == ADCX_OFS_STATUS_CFG |=>
      excitation_current_setting_o == $past(shreg[2:0]))
    else $error("current setting not written");
  chk_route1_write: assert property (@(posedge core_clk_i) disable iff (rst_i) // see R6
    wr_fire && ptr == ADCX_OFS_ROUTING |=> first_source_route_o == $past(shreg[7:5]))
    else $error("first route not written");
  chk_route2_write: assert property (@(posedge core_clk_i) disable iff (rst_i) // see R7
    wr_fire && ptr == ADCX_OFS_ROUTING |=> second_source_route_o == $past(shreg[4:2]))
    else $error("second route not written");
  chk_rsvd_zero: assert property (@(posedge core_clk_i) disable iff (rst_i) // see R8
    state == ADCX_ST_RDATA && ptr == ADCX_OFS_ROUTING && bit_cnt[2:0] >= 3'h6 |-> sda_oe_o)
    else $error("reserved routing bits not read as zero");
  chk_route_addr: assert property (@(posedge core_clk_i) disable iff (rst_i) // see R9
    wr_fire && ptr != ADCX_OFS_ROUTING |=> $stable(route))
    else $error("routing changed by write elsewhere");
  chk_cfg_addr: assert property (@(posedge core_clk_i) disable iff (rst_i) // see R14
    wr_fire && ptr != ADCX_OFS_STATUS_CFG |=> $stable(cfg))
    else $error("config changed by write elsewhere");
  chk_sda_timing: assert property (@(posedge core_clk_i) disable iff (rst_i) // see R10
    $rose(sda_oe_o) |-> $past(scl_fall))
    else $error("sda driven away from a falling clock");
  chk_addr_ack: assert property (@(posedge core_clk_i) disable iff (rst_i) // see R12
    s_addr_match |=> s_acked)
    else $error("own address not acknowledged");
  chk_ready_pin: assert property (@(posedge core_clk_i) disable iff (rst_i) // see R13
    conv_done_i |=> ready_pin_oe_o && !ready_pin_o)
    else $error("ready pin not pulled low");

endmodule

// file: design/adcx_pkg.sv
// register map, field layout and protocol states of the auxiliary config bank
// shared by the bank and its strap decoder; no timing of its own
package adcx_pkg;

  // ==========================================================================
  // register offsets and reset values
  localparam logic [7:0] ADCX_OFS_STATUS_CFG = 8'h02; // status_and_excitation_config
  localparam logic [7:0] ADCX_OFS_ROUTING    = 8'h03; // excitation_routing
  localparam logic [7:0] ADCX_RST_STATUS_CFG = 8'h00;
  localparam logic [7:0] ADCX_RST_ROUTING    = 8'h00;
  localparam logic [7:0] ADCX_RD_UNMAPPED    = 8'h00;

  // ==========================================================================
  // field positions, status_and_excitation_config
  localparam int ADCX_POS_READY   = 7;
  localparam int ADCX_POS_DATA_COUNTER_ENABLE    = 6;
  localparam int ADCX_POS_INTEG_H = 5;
  localparam int ADCX_POS_INTEG_L = 4;
  localparam int ADCX_POS_BURNOUT = 3;
  localparam int ADCX_POS_CURR_H  = 2;
  localparam int ADCX_POS_CURR_L  = 0;

  // field positions, excitation_routing
  localparam int ADCX_POS_ROUTE1_H = 7;
  localparam int ADCX_POS_ROUTE1_L = 5;
  localparam int ADCX_POS_ROUTE2_H = 4;
  localparam int ADCX_POS_ROUTE2_L = 2;
  localparam logic [1:0] ADCX_ROUTE_RSVD_VAL = 2'h0;

  // ==========================================================================
  // field encodings
  localparam logic [1:0] ADCX_INTEG_NONE    = 2'h0;
  localparam logic [1:0] ADCX_INTEG_INVERT  = 2'h1;
  localparam logic [1:0] ADCX_INTEG_CRC16   = 2'h2;
  localparam logic [2:0] ADCX_CURR_OFF      = 3'h0;
  localparam logic [2:0] ADCX_CURR_10UA     = 3'h1;
  localparam logic [2:0] ADCX_CURR_50UA     = 3'h2;
  localparam logic [2:0] ADCX_CURR_250UA    = 3'h4;
  localparam logic [2:0] ADCX_CURR_500UA    = 3'h5;
  localparam logic [2:0] ADCX_CURR_1500UA   = 3'h7;
  localparam logic [2:0] ADCX_ROUTE_OFF     = 3'h0;
  localparam logic [2:0] ADCX_ROUTE_ANALOG_INPUT_ZERO    = 3'h1;
  localparam logic [2:0] ADCX_ROUTE_REFERENCE_POSITIVE_INPUT    = 3'h5;
  localparam logic [2:0] ADCX_ROUTE_REFERENCE_NEGATIVE_INPUT    = 3'h6;

  // ==========================================================================
  // serial target constants
  localparam logic [3:0] ADCX_BYTE_BITS     = 4'h8;
  localparam logic [2:0] ADCX_LAST_OUT_BIT  = 3'h7;
  localparam logic [6:0] ADCX_ADDR_BASE_RST = 7'h00;

  typedef enum logic [3:0] {
    ADCX_ST_IDLE,
    ADCX_ST_ADDR,
    ADCX_ST_ADDR_ACK,
    ADCX_ST_PTR,
    ADCX_ST_PTR_ACK,
    ADCX_ST_WDATA,
    ADCX_ST_WDATA_ACK,
    ADCX_ST_RDATA,
    ADCX_ST_RDATA_ACK
  } adcx_state_t;

endpackage
